// *** common/lil_pkg.sv ***
// lamp logic package: sizes, config fields, appearance codes, blink timing
// assumes a 100 MHz core clock
package lil_pkg;
  localparam int NUM_LAMPS = 8;
  localparam int NUM_SLOTS = 5;
  localparam int SIG_W     = 32;
  localparam int SEL_W     = 6;
  localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;
  localparam logic [SEL_W-1:0] SEL_MAX  = 6'h20;
  localparam int CLK_MHZ        = 100;
  localparam int BLINK_HALF_MS  = 500;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int BLINK_CNT_W    = 26;

  typedef enum logic [2:0] {
    LIL_APP_NONE        = 3'h0,
    LIL_APP_GREEN       = 3'h1,
    LIL_APP_RED         = 3'h2,
    LIL_APP_RED_FLASH   = 3'h3,
    LIL_APP_GREEN_FLASH = 3'h4
  } lil_app_t;

  typedef enum logic [1:0] {
    LIL_LATCH_OFF          = 2'h0,
    LIL_LATCH_ON           = 2'h1,
    LIL_LATCH_CLEAR_ALARM  = 2'h2
  } lil_latch_t;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic             inv;
  } lil_slot_t;

  typedef struct packed {
    lil_slot_t [NUM_SLOTS-1:0] slots;
    lil_latch_t                mode;
    lil_app_t                  act_app;
    lil_app_t                  inact_app;
  } lil_lamp_cfg_t;

  typedef struct packed {
    logic red;
    logic green;
  } lil_led_t;
endpackage

// *** rtl/lil_blink.sv ***
// free-running blink divider shared by all flashing lamps
// assumes a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module lil_blink #(
  parameter int HALF_CYC = lil_pkg::BLINK_HALF_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  output logic      phase_o
);
  localparam int            CW   = lil_pkg::BLINK_CNT_W;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);
  logic [CW-1:0]            cnt_reg;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      phase_o <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
      phase_o <= ~phase_o;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** rtl/lil_lamps.sv ***
// indicator lamp block: trigger conditioning, latching, acknowledge, colours
// assumes all inputs synchronous to core_clk_i, acknowledges are one-cycle pulses
// Function
// - each lamp ORs up to five conditioned trigger inputs
// - each trigger slot has its own inversion setting
// - an unassigned slot always contributes zero, inversion ignored
// - latching lamp stores active state until a valid reset condition
// - non-latching lamp follows its combined triggers directly
// - per-lamp acknowledge acts only when latching, and only with triggers inactive
// - active lamp shows configured active appearance
// - inactive lamp shows separately configured inactive appearance
// - a reset condition clears the latch only with all triggers dropped out
// - switching to non-latching clears the stored latch
// - lamp with all slots unassigned has its latch cleared
// - latched states survive warm restarts (rst_i); the power-on clear por_i empties the retention store
// - global lamp acknowledge acks all latched lamps, each still trigger-gated
// - global and remote ack-all work only with remote reset permitted
// - ack-by-alarm mode acks all lamps on any protection alarm
// - system-ok lamp flashes green in boot, steady green afterwards
// - life contact relay energised only after good start without faults
`timescale 1ns/1ps
`default_nettype none
module lil_lamps #(
  parameter int BLINK_HALF_CYC = lil_pkg::BLINK_HALF_CYC
) (
  input  wire logic                                        core_clk_i,
  input  wire logic                                        rst_i,
  input  wire logic                                        por_i,
  input  wire logic [lil_pkg::SIG_W-1:0]                   sig_i,
  input  wire lil_pkg::lil_lamp_cfg_t [lil_pkg::NUM_LAMPS-1:0] lamp_cfg_i,
  input  wire logic [lil_pkg::NUM_LAMPS-1:0]               lamp_ack_i,
  input  wire logic                                        clear_key_i,
  input  wire logic                                        global_lamp_acknowledge_i,
  input  wire logic                                        remote_ack_all_i,
  input  wire logic                                        remote_reset_en_i,
  input  wire logic                                        prot_alarm_i,
  input  wire logic                                        boot_done_i,
  input  wire logic                                        internal_fault_i,
  output lil_pkg::lil_led_t [lil_pkg::NUM_LAMPS-1:0]       lamp_led_o,
  output logic [lil_pkg::NUM_LAMPS-1:0]                    lamp_state_o,
  output logic [lil_pkg::NUM_LAMPS-1:0]                    latch_o,
  output logic                                             sysok_green_o,
  output logic                                             life_contact_relay_o
);
  localparam int NL = lil_pkg::NUM_LAMPS;
  localparam int NS = lil_pkg::NUM_SLOTS;
  localparam int IW = $clog2(lil_pkg::SIG_W);

  // conditioned value of one slot
  function automatic logic slot_val(input lil_pkg::lil_slot_t s, input logic [lil_pkg::SIG_W-1:0] sig);
    logic v;
    v = 1'b0;
    if (s.sel != lil_pkg::SEL_NONE && s.sel <= lil_pkg::SEL_MAX) begin
      v = sig[IW'(s.sel - 1'b1)] ^ s.inv;
    end
    return v;
  endfunction

  // appearance code to red/green drive
  function automatic lil_pkg::lil_led_t app_drive(input lil_pkg::lil_app_t a, input logic ph);
    lil_pkg::lil_led_t d;
    d = '0;
    unique case (a)
      lil_pkg::LIL_APP_NONE:        d = '0;
      lil_pkg::LIL_APP_GREEN:       d.green = 1'b1;
      lil_pkg::LIL_APP_RED:         d.red = 1'b1;
      lil_pkg::LIL_APP_RED_FLASH:   d.red = ph;
      lil_pkg::LIL_APP_GREEN_FLASH: d.green = ph;
      default:                      d = '0;
    endcase
    return d;
  endfunction

  logic            blink_ph;
  logic [NL-1:0]   retain_rd;
  logic            restore_reg;
  logic            alarm_d_reg;
  logic [NL-1:0]   latch_reg;
  logic [NL-1:0]   latch_next;
  logic [NL-1:0]   trig_any;
  logic [NL-1:0]   unassigned_all;
  logic [NL-1:0]   latching;
  logic [NL-1:0]   state_next;
  logic            alarm_mode_any;
  logic            alarm_ack;
  logic            remote_all_ack;
  logic [NL-1:0]   ack_any;

  lil_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .phase_o    (blink_ph)
  );

  lil_retain #(.W(NL)) u_retain (
    .core_clk_i (core_clk_i),
    .clr_i      (por_i),
    .wr_en_i    (~rst_i & ~restore_reg),
    .wr_data_i  (latch_next),
    .rd_data_o  (retain_rd)
  );

  // trigger conditioning per lamp
  always_comb begin
    trig_any       = '0;
    unassigned_all = '1;
    latching       = '0;
    alarm_mode_any = 1'b0;
    for (int l = 0; l < NL; l++) begin
      for (int s = 0; s < NS; s++) begin
        trig_any[l] = trig_any[l] | slot_val(lamp_cfg_i[l].slots[s], sig_i);
        if (lamp_cfg_i[l].slots[s].sel != lil_pkg::SEL_NONE) begin
          unassigned_all[l] = 1'b0;
        end
      end
      latching[l] = lamp_cfg_i[l].mode != lil_pkg::LIL_LATCH_OFF;
      if (lamp_cfg_i[l].mode == lil_pkg::LIL_LATCH_CLEAR_ALARM) begin
        alarm_mode_any = 1'b1;
      end
    end
  end

  assign alarm_ack      = alarm_mode_any & prot_alarm_i & ~alarm_d_reg;
  assign remote_all_ack = remote_reset_en_i & (global_lamp_acknowledge_i | remote_ack_all_i);
  assign ack_any        = {NL{clear_key_i | remote_all_ack | alarm_ack}} | lamp_ack_i;

  // latch next value
  always_comb begin
    latch_next = '0;
    state_next = '0;
    for (int l = 0; l < NL; l++) begin
      if (!latching[l] || unassigned_all[l]) begin
        latch_next[l] = 1'b0;
      end else if (trig_any[l]) begin
        latch_next[l] = 1'b1;
      end else if (ack_any[l]) begin
        latch_next[l] = 1'b0;
      end else begin
        latch_next[l] = latch_reg[l];
      end
      state_next[l] = latching[l] ? latch_next[l] : trig_any[l];
    end
  end

  // restore latches from the retention store after a restart
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      restore_reg <= 1'b1;
    end else begin
      restore_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      latch_reg <= '0;
    end else if (restore_reg) begin
      latch_reg <= retain_rd;
    end else begin
      latch_reg <= latch_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      alarm_d_reg <= 1'b0;
    end else begin
      alarm_d_reg <= prot_alarm_i;
    end
  end

  // displayed lamp state
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lamp_state_o <= '0;
      latch_o      <= '0;
    end else if (restore_reg) begin
      lamp_state_o <= lamp_state_o;
      latch_o      <= latch_o;
    end else begin
      lamp_state_o <= state_next;
      latch_o      <= latch_next;
    end
  end

  // colour drive from the common blink phase
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lamp_led_o <= '0;
    end else begin
      for (int l = 0; l < NL; l++) begin
        if (lamp_state_o[l]) begin
          lamp_led_o[l] <= app_drive(lamp_cfg_i[l].act_app, blink_ph);
        end else begin
          lamp_led_o[l] <= app_drive(lamp_cfg_i[l].inact_app, blink_ph);
        end
      end
    end
  end

  // fixed system-ok lamp and life contact
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sysok_green_o        <= 1'b0;
      life_contact_relay_o <= 1'b0;
    end else begin
      sysok_green_o        <= boot_done_i ? 1'b1 : blink_ph;
      life_contact_relay_o <= boot_done_i & ~internal_fault_i;
    end
  end

  // checks on lamp 0, on the whole latch at restore, and on the fixed outputs
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // latch set, hold and clear
  latch_set_a: assert property (!restore_reg && latching[0] && !unassigned_all[0] && trig_any[0]
                                |=> latch_reg[0] && latch_o[0])
    else $error("latch did not set on active trigger");

  state_mirror_a: assert property (!restore_reg && latching[0] |=> lamp_state_o[0] == latch_o[0])
    else $error("latched lamp state differs from latch");

  latch_hold_a: assert property (!restore_reg && latching[0] && latch_reg[0] && trig_any[0]
                                 && ack_any[0] |=> latch_reg[0])
    else $error("latch cleared while trigger active");

  lamp_ack_a: assert property (!restore_reg && latching[0] && !unassigned_all[0] && latch_reg[0]
                               && !trig_any[0] && lamp_ack_i[0] |=> !latch_reg[0])
    else $error("lamp ack did not clear latch");

  clear_key_a: assert property (!restore_reg && latching[0] && !unassigned_all[0] && !trig_any[0]
                                && clear_key_i |=> !latch_reg[0])
    else $error("clear key did not clear latch");

  follow_a: assert property (!restore_reg && !latching[0] |=> lamp_state_o[0] == $past(trig_any[0])
                             && !latch_reg[0])
    else $error("non-latching lamp did not follow triggers");

  mode_off_a: assert property (!restore_reg && !latching[0] |=> !latch_o[0])
    else $error("latch output kept in non-latching mode");

  // acknowledge sources, unassigned slots and restore
  remote_gate_a: assert property (!restore_reg && !remote_reset_en_i && latching[0] && !unassigned_all[0]
                                  && latch_reg[0] && !clear_key_i && !lamp_ack_i[0] && !alarm_ack
                                  |=> latch_reg[0])
    else $error("global ack acted without permission");

  global_ack_a: assert property (!restore_reg && remote_reset_en_i && global_lamp_acknowledge_i
                                 && latching[0] && !trig_any[0] |=> !latch_reg[0])
    else $error("global ack did not clear latch");

  remote_ack_a: assert property (!restore_reg && remote_reset_en_i && remote_ack_all_i
                                 && latching[0] && !trig_any[0] |=> !latch_reg[0])
    else $error("remote ack did not clear latch");

  unassigned_a: assert property (!restore_reg && unassigned_all[0] |=> !latch_reg[0])
    else $error("latch kept with no slot assigned");

  empty_slots_a: assert property (!restore_reg && unassigned_all[0] |=> !lamp_state_o[0])
    else $error("lamp active with no slot assigned");

  restore_a: assert property (restore_reg |=> latch_reg == $past(retain_rd))
    else $error("latch not restored after restart");

  alarm_ack_a: assert property (!restore_reg && alarm_mode_any && $rose(prot_alarm_i) && latching[0]
                                && !trig_any[0] |=> !latch_reg[0])
    else $error("alarm did not acknowledge lamp");

  alarm_gate_a: assert property (!restore_reg && !alarm_mode_any && latching[0] && !unassigned_all[0]
                                 && latch_reg[0] && !clear_key_i && !remote_all_ack && !lamp_ack_i[0]
                                 |=> latch_reg[0])
    else $error("alarm acted with no lamp in alarm mode");

  // appearance and fixed outputs
  colour_a: assert property (lamp_state_o[0] && lamp_cfg_i[0].act_app == lil_pkg::LIL_APP_GREEN
                             |=> lamp_led_o[0].green && !lamp_led_o[0].red)
    else $error("active green appearance wrong");

  inact_colour_a: assert property (!lamp_state_o[0] && lamp_cfg_i[0].inact_app == lil_pkg::LIL_APP_RED
                                   |=> lamp_led_o[0].red && !lamp_led_o[0].green)
    else $error("inactive red appearance wrong");

  sysok_a: assert property (boot_done_i |=> sysok_green_o)
    else $error("system ok lamp not steady after boot");

  sysok_flash_a: assert property (!boot_done_i |=> sysok_green_o == $past(blink_ph))
    else $error("system ok lamp not flashing in boot");

  relay_a: assert property (!boot_done_i || internal_fault_i |=> !life_contact_relay_o)
    else $error("life contact energised too early");

  relay_on_a: assert property (boot_done_i && !internal_fault_i |=> life_contact_relay_o)
    else $error("life contact not energised");

  // scenario covers
  latch_set_c: cover property (trig_any[0] && latching[0] ##1 !trig_any[0] [*2] ##1 latch_reg[0]);
  ack_clear_c: cover property (latch_reg[0] && !trig_any[0] && lamp_ack_i[0] ##1 !latch_reg[0]);
  alarm_ack_c: cover property (alarm_ack && latch_reg[0] ##1 !latch_reg[0]);
  restore_c:   cover property (restore_reg && retain_rd[0] ##1 latch_reg[0]);
  sysok_flash_c: cover property (!boot_done_i && sysok_green_o ##1 !sysok_green_o);
endmodule
`default_nettype wire

// *** rtl/lil_retain.sv ***
// retention store for latched lamp states, survives restarts
// cleared only by the power-on clear; read data registered
`timescale 1ns/1ps
`default_nettype none
module lil_retain #(
  parameter int W = lil_pkg::NUM_LAMPS
) (
  input  wire logic         core_clk_i,
  input  wire logic         clr_i,
  input  wire logic         wr_en_i,
  input  wire logic [W-1:0] wr_data_i,
  output logic      [W-1:0] rd_data_o
);
  logic [W-1:0] mem_reg;

  always_ff @(posedge core_clk_i) begin
    if (clr_i) begin
      mem_reg <= '0;
    end else if (wr_en_i) begin
      mem_reg <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clr_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_reg;
    end
  end
endmodule
`default_nettype wire

// *** verif/lil_src_model.sv ***
// source model: presents protection trigger signals to the lamp block
// assumes the bench changes want_i on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module lil_src_model (
  input  wire logic [lil_pkg::SIG_W-1:0] want_i,
  output logic      [lil_pkg::SIG_W-1:0] sig_o
);
  // triggers are plain levels, always driven
  assign sig_o = want_i;
endmodule
`default_nettype wire

// *** verif/test_latched_indicator_lamp_logic.sv ***
// self-checking bench for the indicator lamp block
// assumes lil_pkg is compiled first; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_latched_indicator_lamp_logic;
  logic                                     core_clk_i = 1'b0;
  logic                                     rst_i = 1'b1;
  logic                                     por_i = 1'b1;
  logic [lil_pkg::SIG_W-1:0]                want = '0;
  logic [lil_pkg::SIG_W-1:0]                sig;
  lil_pkg::lil_lamp_cfg_t [lil_pkg::NUM_LAMPS-1:0] cfg = '0;
  logic [lil_pkg::NUM_LAMPS-1:0]            ack = '0;
  logic                                     ckey = 1'b0;
  logic                                     gack = 1'b0;
  logic                                     rack = 1'b0;
  logic                                     ren = 1'b0;
  logic                                     alarm = 1'b0;
  logic                                     boot = 1'b0;
  logic                                     fault = 1'b0;
  lil_pkg::lil_led_t [lil_pkg::NUM_LAMPS-1:0] led;
  logic [lil_pkg::NUM_LAMPS-1:0]            st;
  logic [lil_pkg::NUM_LAMPS-1:0]            lat;
  logic                                     sysok;
  logic                                     relay;
  logic                                     s0;
  int                                       n_mismatch = 0;
  int                                       tests_run = 0;
  int                                       cyc = 0;

  lil_src_model i_lil_src_model (.want_i(want), .sig_o(sig));
  lil_lamps #(.BLINK_HALF_CYC(4)) i_lil_lamps (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .por_i(por_i), .sig_i(sig),
    .lamp_cfg_i(cfg), .lamp_ack_i(ack), .clear_key_i(ckey),
    .global_lamp_acknowledge_i(gack), .remote_ack_all_i(rack),
    .remote_reset_en_i(ren), .prot_alarm_i(alarm), .boot_done_i(boot),
    .internal_fault_i(fault), .lamp_led_o(led), .lamp_state_o(st),
    .latch_o(lat), .sysok_green_o(sysok), .life_contact_relay_o(relay));

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // run ceiling, well above the fewer than one hundred cycles the tests need
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic chk_b(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp || $isunknown(exp)) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic chk_l(input lil_pkg::lil_led_t got, input lil_pkg::lil_led_t exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // raise then drop the trigger of lamp 0 (and of lamp 2, same source)
  task automatic latch0();
    want[0] = 1'b1;
    step(1);
    want[0] = 1'b0;
    step(1);
  endtask

  task automatic t_sysok();
    s0 = sysok;
    step(4);
    chk_b(sysok, ~s0, "boot flash");
    chk_b(relay, 1'b0, "relay off in boot");
    boot = 1'b1;
    step(2);
    chk_b(sysok, 1'b1, "steady green");
    chk_b(relay, 1'b1, "relay on");
    fault = 1'b1;
    step(2);
    chk_b(relay, 1'b0, "relay off on fault");
    fault = 1'b0;
    $display("test sysok done");
  endtask

  task automatic t_latch();
    cfg[0].slots[0].sel = 6'h01;
    cfg[0].mode = lil_pkg::LIL_LATCH_ON;
    cfg[0].act_app = lil_pkg::LIL_APP_GREEN;
    cfg[0].inact_app = lil_pkg::LIL_APP_RED;
    want[0] = 1'b1;
    step(1);
    chk_b(lat[0], 1'b1, "latch set");
    chk_b(st[0], 1'b1, "lamp active");
    step(1);
    chk_l(led[0], 2'b01, "active app");
    want[0] = 1'b0;
    step(2);
    chk_b(lat[0], 1'b1, "latch held");
    want[0] = 1'b1;
    ack[0] = 1'b1;
    step(1);
    want[0] = 1'b0;
    chk_b(lat[0], 1'b1, "ack refused");
    step(1);
    ack[0] = 1'b0;
    chk_b(lat[0], 1'b0, "ack clears");
    step(1);
    chk_l(led[0], 2'b10, "inactive app");
    $display("test latch done");
  endtask

  task automatic t_follow();
    cfg[1].slots[0] = '{sel: 6'h02, inv: 1'b1};
    cfg[1].slots[1].inv = 1'b1;
    step(1);
    chk_b(st[1], 1'b1, "inverted slot");
    want[1] = 1'b1;
    step(1);
    chk_b(st[1], 1'b0, "unassigned slot zero");
    chk_b(lat[1], 1'b0, "no storage");
    $display("test follow done");
  endtask

  task automatic t_flash();
    logic r0;
    cfg[3].slots[0].sel = 6'h04;
    cfg[3].act_app = lil_pkg::LIL_APP_RED_FLASH;
    cfg[4].inact_app = lil_pkg::LIL_APP_GREEN_FLASH;
    want[3] = 1'b1;
    step(2);
    r0 = led[3].red;
    repeat (4) begin
      chk_b(led[3].green, 1'b0, "red flash only red");
      chk_b(led[3].red, led[4].green, "flash in phase");
      step(1);
    end
    chk_b(led[3].red, ~r0, "red flash toggles");
    want[3] = 1'b0;
    cfg[3].inact_app = lil_pkg::LIL_APP_GREEN_FLASH;
    step(2);
    chk_b(led[3].red, 1'b0, "inactive flash no red");
    chk_b(led[3].green, led[4].green, "inactive flash in phase");
    $display("test flash done");
  endtask

  task automatic t_acks();
    latch0();
    gack = 1'b1;
    step(1);
    gack = 1'b0;
    chk_b(lat[0], 1'b1, "global gated");
    rack = 1'b1;
    step(1);
    rack = 1'b0;
    chk_b(lat[0], 1'b1, "remote gated");
    ren = 1'b1;
    gack = 1'b1;
    step(1);
    gack = 1'b0;
    chk_b(lat[0], 1'b0, "global ack");
    latch0();
    rack = 1'b1;
    step(1);
    rack = 1'b0;
    chk_b(lat[0], 1'b0, "remote ack");
    ren = 1'b0;
    latch0();
    ckey = 1'b1;
    step(1);
    ckey = 1'b0;
    chk_b(lat[0], 1'b0, "clear key");
    $display("test acks done");
  endtask

  task automatic t_alarm();
    cfg[2] = cfg[0];
    latch0();
    alarm = 1'b1;
    step(1);
    alarm = 1'b0;
    chk_b(lat[2], 1'b1, "alarm ignored without mode");
    cfg[0].mode = lil_pkg::LIL_LATCH_CLEAR_ALARM;
    step(1);
    chk_b(lat[2], 1'b1, "second lamp latched");
    alarm = 1'b1;
    step(1);
    alarm = 1'b0;
    chk_b(lat[0], 1'b0, "alarm ack");
    chk_b(lat[2], 1'b0, "alarm acks all");
    cfg[0].mode = lil_pkg::LIL_LATCH_ON;
    $display("test alarm done");
  endtask

  task automatic t_cfg();
    latch0();
    cfg[0].mode = lil_pkg::LIL_LATCH_OFF;
    step(1);
    chk_b(lat[0], 1'b0, "mode off clears");
    cfg[0].mode = lil_pkg::LIL_LATCH_ON;
    latch0();
    cfg[0].slots[0].sel = 6'h00;
    step(1);
    chk_b(lat[0], 1'b0, "no slots clears");
    cfg[0].slots[0].sel = 6'h01;
    $display("test config done");
  endtask

  task automatic t_restart();
    latch0();
    rst_i = 1'b1;
    step(2);
    rst_i = 1'b0;
    step(2);
    chk_b(lat[0], 1'b1, "latch restored");
    $display("test restart done");
  endtask

  initial begin
    step(20);
    rst_i = 1'b0;
    por_i = 1'b0;
    step(2);
    t_sysok();
    t_latch();
    t_follow();
    t_flash();
    t_acks();
    t_alarm();
    t_cfg();
    t_restart();
    conclude();
  end
endmodule
`default_nettype wire
